// *** flash_power_id_commands.sv ***
// Power-state and identification command handling of a serial flash
// Functional notes
// - Only the sleep opcode enters deep sleep; asleep, write/program/erase commands are dropped.
// - In deep sleep every command is ignored except wake-and-identify.
// - Sleep executes only when select rises right after the eighth bit.
// - Select high with no internal cycle means ordinary standby, not sleep.
// - Deep sleep is reached only after the sleep entry delay.
// - Sleep request during a busy write cycle is rejected, cycle untouched.
// - Power-up always lands in standby.
// - Wake-only release accepts commands again only after the wake-only delay.
// - Wake opcode plus three dummy bytes returns device code repeatedly, MSB first.
// - Wake with code from sleep accepts commands after the second delay.
// - Wake/identify while busy writing is ignored.
// - Opcode 90h with address zero returns maker then part code.
// - Address one with opcode 90h returns part code first.
// - Opcode 9fh returns maker, memory type, capacity on falling edges.
// - Opcode 9fh during a busy cycle is not decoded.
// - Select rise ends identity output; device returns to standby.
// - Wake, write enable or sleep opcodes leave pump mode.
// - Stream mode bits set: standard commands are not recognised.
// - Opcode ffh clears stream mode so standard commands work again.
// - Status reads zero as delivered.
// - Sleep and wake delays at most 0.1 us, pump entry at most 0.2 us.
// - Busy flag reads one during program/erase, zero after.
`timescale 1ns/1ps

module flash_power_id_commands #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h3c, // Arbitrary value
  parameter logic [7:0] MEMORY_TYPE = 8'h41, // Arbitrary value
  parameter logic [7:0] CAPACITY_CODE = 8'h12 // Arbitrary value
) (
  // System clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Write engine and read engine
  input wire logic busy_writing_flag,
  input wire logic stream_load,
  input wire logic [7:0] stream_read_mode_bits,
  // Decoded commands to the rest of the chip
  output logic cmd_strobe,
  output logic [7:0] cmd_opcode,
  output logic [5:0] cmd_bit_count,
  output logic cmd_overlong,
  // Power and mode state
  output logic deep_sleep,
  output logic commands_ready,
  output logic pump_precharge_mode,
  output logic stream_mode_active,
  output logic [7:0] status_value
);

  // ---------------- Link domain (serial clock) ----------------
  logic frame_start_reg;
  logic [5:0] bit_cnt_reg;
  logic long_reg;
  logic [7:0] shift_reg;
  logic [7:0] opcode_reg;
  logic addr_lsb_reg;
  logic [2:0] lk_s1_reg;
  logic [2:0] lk_s2_reg;
  logic [2:0] lk_s3_reg;
  logic [2:0] lk_lvl_reg;
  logic so_reg;
  logic so_oe_reg;

  // Levels handed from the system domain: busy, not-standby, stream
  logic [2:0] lk_src;
  logic busy_l;
  logic asleep_l;
  logic stream_l;

  // Armed by select high, cleared at the first edge of a frame
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      frame_start_reg <= 1'b1;
    end else begin
      frame_start_reg <= 1'b0;
    end
  end

  // Bit counter and input shift, MSB first on rising edges
  wire [5:0] bit_cnt_next = frame_start_reg ? 6'h01 : 6'(bit_cnt_reg + 6'h01);
  wire long_next = frame_start_reg ? 1'b0 :
                   (long_reg | (bit_cnt_reg == flash_power_id_pkg::BIT_COUNT_MAX));
  wire opcode_take = ~frame_start_reg & ~long_reg &
                     (bit_cnt_reg == flash_power_id_pkg::OPCODE_LAST_BIT);
  wire addr_take = ~frame_start_reg & ~long_reg &
                   (bit_cnt_reg == flash_power_id_pkg::ADDR_LSB_BIT);

  always_ff @(posedge sclk) begin
    bit_cnt_reg <= bit_cnt_next;
    long_reg <= long_next;
    shift_reg <= {shift_reg[6:0], si};
    if (opcode_take) begin
      opcode_reg <= {shift_reg[6:0], si};
    end
    if (addr_take) begin
      addr_lsb_reg <= si;
    end
  end

  // Three-stage crossing of state levels into the link domain
  always_ff @(posedge sclk) begin
    lk_s1_reg <= lk_src;
    lk_s2_reg <= lk_s1_reg;
    lk_s3_reg <= lk_s2_reg;
    lk_lvl_reg <= (lk_s2_reg & ~(lk_s2_reg ^ lk_s3_reg)) | (lk_lvl_reg & (lk_s2_reg ^ lk_s3_reg));
  end

  assign busy_l = lk_lvl_reg[2];
  assign asleep_l = lk_lvl_reg[1];
  assign stream_l = lk_lvl_reg[0];

  // Output byte and bit selection
  wire past_header = long_reg | (bit_cnt_reg >= flash_power_id_pkg::HEADER_BITS);
  wire [2:0] bit_pos = 3'(3'h7 - bit_cnt_reg[2:0]);
  wire [1:0] id_idx = 2'(bit_cnt_reg[4:3] - 2'h1);
  wire [7:0] three_byte = (id_idx == 2'h0) ? MAKER_CODE :
                          (id_idx == 2'h1) ? MEMORY_TYPE :
                          (id_idx == 2'h2) ? CAPACITY_CODE : 8'h00;
  wire [7:0] pair_byte = (bit_cnt_reg[3] ^ addr_lsb_reg) ? DEVICE_CODE : MAKER_CODE;
  wire wake_code_go = (opcode_reg == flash_power_id_pkg::OP_WAKE_IDENT) & past_header &
                      ~busy_l & ~stream_l;
  wire pair_go = (opcode_reg == flash_power_id_pkg::OP_MAKER_PART) & past_header &
                 ~asleep_l & ~stream_l;
  wire three_go = (opcode_reg == flash_power_id_pkg::OP_THREE_ID) & ~long_reg &
                  (bit_cnt_reg >= flash_power_id_pkg::OPCODE_BITS) &
                  (bit_cnt_reg < flash_power_id_pkg::HEADER_BITS) &
                  ~asleep_l & ~stream_l & ~busy_l;
  wire out_go = wake_code_go | pair_go | three_go;
  wire out_bit = wake_code_go ? DEVICE_CODE[bit_pos] :
                 pair_go ? pair_byte[bit_pos] :
                 three_byte[bit_pos];

  // Falling-edge output; select high stops it at once
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
    end else begin
      so_reg <= out_go & out_bit;
      so_oe_reg <= out_go;
    end
  end

  assign so = so_reg;
  assign so_oe = so_oe_reg;

  // ---------------- System domain ----------------
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_s3_reg;
  logic cs_lvl_reg;
  flash_power_id_pkg::power_state_t state_reg;
  flash_power_id_pkg::power_state_t state_next;
  logic [4:0] delay_cnt_reg;
  logic [4:0] delay_cnt_next;
  logic [4:0] pump_cnt_reg;
  logic pump_reg;
  logic stream_reg;
  logic cmd_strobe_reg;
  logic [7:0] cmd_opcode_reg;
  logic [5:0] cmd_bit_count_reg;
  logic cmd_overlong_reg;
  logic [7:0] status_reg;

  // Select through three flops; a change counts when stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      cs_lvl_reg <= 1'b1;
    end else begin
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      if (cs_s2_reg == cs_s3_reg) begin
        cs_lvl_reg <= cs_s2_reg;
      end
    end
  end

  // Frame summary; link registers stand still while select is high
  wire cs_rise = cs_s2_reg & cs_s3_reg & ~cs_lvl_reg;
  wire [7:0] f_opc = opcode_reg;
  wire exact8 = ~long_reg & (bit_cnt_reg == flash_power_id_pkg::OPCODE_BITS);
  wire exact32 = ~long_reg & (bit_cnt_reg == flash_power_id_pkg::HEADER_BITS);
  wire ge8 = long_reg | (bit_cnt_reg >= flash_power_id_pkg::OPCODE_BITS);
  wire ge32 = long_reg | (bit_cnt_reg >= flash_power_id_pkg::HEADER_BITS);
  wire in_standby = (state_reg == flash_power_id_pkg::ps_standby);
  wire open_cmd = cs_rise & in_standby & ~stream_reg;
  wire delay_done = (delay_cnt_reg == 5'h01);

  // Command decode at the end of a frame
  wire sleep_req = open_cmd & (f_opc == flash_power_id_pkg::OP_DEEP_SLEEP) & exact8 &
                   ~busy_writing_flag;
  wire wake_req = cs_rise & (state_reg == flash_power_id_pkg::ps_asleep) &
                  (f_opc == flash_power_id_pkg::OP_WAKE_IDENT) & (exact8 | ge32) &
                  ~busy_writing_flag;
  wire pump_req = open_cmd & (f_opc == flash_power_id_pkg::OP_PUMP_ENTER) & exact32;
  wire pump_clear = sleep_req |
                    (open_cmd & (f_opc == flash_power_id_pkg::OP_WAKE_IDENT) & ge8) |
                    (open_cmd & (f_opc == flash_power_id_pkg::OP_WRITE_ENABLE) & exact8);
  wire stream_clear = cs_rise & in_standby & stream_reg & ge8 &
                      (f_opc == flash_power_id_pkg::OP_STREAM_EXIT);
  wire stream_set = stream_read_mode_bits[7:4] == flash_power_id_pkg::STREAM_MODE_KEY;
  wire cmd_fwd = open_cmd & ge8;

  // Power state sequencing
  always_comb begin
    state_next = state_reg;
    delay_cnt_next = (delay_cnt_reg != 5'h00) ? 5'(delay_cnt_reg - 5'h01) : 5'h00;
    case (state_reg)
      flash_power_id_pkg::ps_standby: begin
        if (sleep_req) begin
          state_next = flash_power_id_pkg::ps_entering;
          delay_cnt_next = flash_power_id_pkg::SLEEP_ENTRY_CYC;
        end
      end
      flash_power_id_pkg::ps_entering: begin
        if (delay_done) begin
          state_next = flash_power_id_pkg::ps_asleep;
        end
      end
      flash_power_id_pkg::ps_asleep: begin
        if (wake_req) begin
          state_next = flash_power_id_pkg::ps_waking;
          delay_cnt_next = ge32 ? flash_power_id_pkg::WAKE_CODE_CYC :
                                  flash_power_id_pkg::WAKE_ONLY_CYC;
        end
      end
      flash_power_id_pkg::ps_waking: begin
        if (delay_done) begin
          state_next = flash_power_id_pkg::ps_standby;
        end
      end
      default: begin
        state_next = flash_power_id_pkg::ps_standby;
      end
    endcase
  end

  // State and delay registers; reset is power-up
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= flash_power_id_pkg::ps_standby;
      delay_cnt_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      delay_cnt_reg <= delay_cnt_next;
    end
  end

  // Pump precharge mode with its entry delay
  always_ff @(posedge clk) begin
    if (reset) begin
      pump_cnt_reg <= 5'h00;
      pump_reg <= 1'b0;
    end else if (pump_clear) begin
      pump_cnt_reg <= 5'h00;
      pump_reg <= 1'b0;
    end else if (pump_req) begin
      pump_cnt_reg <= flash_power_id_pkg::PUMP_ENTRY_CYC;
    end else if (pump_cnt_reg != 5'h00) begin
      pump_cnt_reg <= 5'(pump_cnt_reg - 5'h01);
      pump_reg <= pump_reg | (pump_cnt_reg == 5'h01);
    end
  end

  // Stream mode flag; a load from the read engine wins over a clear
  always_ff @(posedge clk) begin
    if (reset) begin
      stream_reg <= 1'b0;
    end else if (stream_load) begin
      stream_reg <= stream_set;
    end else if (stream_clear) begin
      stream_reg <= 1'b0;
    end
  end

  // Forwarded commands and status
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_strobe_reg <= 1'b0;
      cmd_opcode_reg <= 8'h00;
      cmd_bit_count_reg <= 6'h00;
      cmd_overlong_reg <= 1'b0;
      status_reg <= flash_power_id_pkg::STATUS_DELIVERY;
    end else begin
      cmd_strobe_reg <= cmd_fwd;
      if (cmd_fwd) begin
        cmd_opcode_reg <= f_opc;
        cmd_bit_count_reg <= bit_cnt_reg;
        cmd_overlong_reg <= long_reg;
      end
      status_reg <= {7'h00, busy_writing_flag};
    end
  end

  assign lk_src = {busy_writing_flag, ~in_standby, stream_reg};
  assign cmd_strobe = cmd_strobe_reg;
  assign cmd_opcode = cmd_opcode_reg;
  assign cmd_bit_count = cmd_bit_count_reg;
  assign cmd_overlong = cmd_overlong_reg;
  assign deep_sleep = (state_reg == flash_power_id_pkg::ps_asleep);
  assign commands_ready = in_standby;
  assign pump_precharge_mode = pump_reg;
  assign stream_mode_active = stream_reg;
  assign status_value = status_reg;

  // ---------------- Checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sleep_exact_a: assert property (
    (cs_rise && in_standby && f_opc == flash_power_id_pkg::OP_DEEP_SLEEP && !exact8)
    |=> state_reg != flash_power_id_pkg::ps_entering)
    else $error("sleep entered on a frame of wrong length");

  sleep_busy_a: assert property (
    (cs_rise && in_standby && busy_writing_flag) |=> state_reg != flash_power_id_pkg::ps_entering)
    else $error("sleep entered while busy writing");

  sleep_delay_a: assert property (
    $rose(state_reg == flash_power_id_pkg::ps_entering)
    |-> ##11 state_reg == flash_power_id_pkg::ps_entering
    ##1 state_reg == flash_power_id_pkg::ps_asleep)
    else $error("sleep entry delay wrong");

  asleep_hold_a: assert property (
    (state_reg == flash_power_id_pkg::ps_asleep && cs_rise &&
     f_opc != flash_power_id_pkg::OP_WAKE_IDENT) |=> state_reg == flash_power_id_pkg::ps_asleep)
    else $error("sleep left on a non-wake command");

  asleep_no_cmd_a: assert property (
    !in_standby |=> !cmd_strobe_reg)
    else $error("command forwarded outside standby");

  wake_delay_a: assert property (
    $rose(state_reg == flash_power_id_pkg::ps_waking)
    |-> ##[1:13] state_reg == flash_power_id_pkg::ps_standby)
    else $error("wake delay too long");

  wake_busy_a: assert property (
    (state_reg == flash_power_id_pkg::ps_asleep && cs_rise && busy_writing_flag)
    |=> state_reg == flash_power_id_pkg::ps_asleep)
    else $error("wake accepted while busy writing");

  pump_exit_a: assert property (
    (open_cmd && exact8 && f_opc == flash_power_id_pkg::OP_WRITE_ENABLE) |=> !pump_reg)
    else $error("pump mode kept after write enable");

  pump_entry_a: assert property (
    (pump_req && !stream_load) |-> ##[1:26] pump_reg)
    else $error("pump entry too slow");

  stream_clear_a: assert property (
    (stream_clear && !stream_load) |=> !stream_reg)
    else $error("stream mode not cleared");

  stream_block_a: assert property (
    stream_reg |=> !cmd_strobe_reg)
    else $error("command forwarded in stream mode");

  status_busy_a: assert property (
    busy_writing_flag |=> status_reg == 8'h01)
    else $error("busy flag not shown");

  id_first_bit_a: assert property (
    @(posedge sclk) disable iff (cs_n)
    (so_oe_reg && opcode_reg == flash_power_id_pkg::OP_THREE_ID && !long_reg &&
     bit_cnt_reg == flash_power_id_pkg::OPCODE_BITS) |-> so_reg == MAKER_CODE[7])
    else $error("identity does not open with maker MSB");

  wake_code_bit_a: assert property (
    @(posedge sclk) disable iff (cs_n)
    (so_oe_reg && opcode_reg == flash_power_id_pkg::OP_WAKE_IDENT && past_header &&
     bit_cnt_reg[2:0] == 3'h0) |-> so_reg == DEVICE_CODE[7])
    else $error("device code byte misaligned");

  sleep_seen_c: cover property ($rose(state_reg == flash_power_id_pkg::ps_asleep));
  wake_seen_c: cover property ($fell(state_reg == flash_power_id_pkg::ps_waking));
  pump_seen_c: cover property ($rose(pump_reg));
  id_out_c: cover property (@(posedge sclk) so_oe_reg && three_go);

endmodule // flash_power_id_commands

// *** flash_power_id_commands_test.sv ***
// Self-checking bench for the power-state and identification command block
`timescale 1ns/1ps
module flash_power_id_commands_test;
  localparam logic [7:0] MAKER_E = 8'hc3; // Arbitrary value
  localparam logic [7:0] DEVICE_E = 8'h27; // Arbitrary value
  localparam logic [7:0] TYPE_E = 8'h60; // Arbitrary value
  localparam logic [7:0] CAP_E = 8'h15; // Arbitrary value
  localparam logic [7:0] CLR_OPS [3] = '{8'hab, 8'h06, 8'hb9};
  localparam int TIMEOUT_CYC = 40000;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sclk, cs_n, si, so, so_oe;
  logic busy_writing_flag = 1'b0;
  logic stream_load = 1'b0;
  logic [7:0] stream_read_mode_bits = 8'h00;
  logic cmd_strobe, cmd_overlong, deep_sleep, commands_ready;
  logic pump_precharge_mode, stream_mode_active;
  logic [7:0] cmd_opcode, status_value;
  logic [5:0] cmd_bit_count;
  logic [63:0] rx;
  logic [13:0] exp_q[$];
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int seed = 32'h1171f5f2;

  always #4 clk = ~clk;

  flash_power_id_commands #(.MAKER_CODE(MAKER_E), .DEVICE_CODE(DEVICE_E),
    .MEMORY_TYPE(TYPE_E), .CAPACITY_CODE(CAP_E)) dut_u (
    .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .busy_writing_flag(busy_writing_flag), .stream_load(stream_load),
    .stream_read_mode_bits(stream_read_mode_bits), .cmd_strobe(cmd_strobe),
    .cmd_opcode(cmd_opcode), .cmd_bit_count(cmd_bit_count), .cmd_overlong(cmd_overlong),
    .deep_sleep(deep_sleep), .commands_ready(commands_ready),
    .pump_precharge_mode(pump_precharge_mode), .stream_mode_active(stream_mode_active),
    .status_value(status_value));

  spi_host_model host_u (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

  // Comparison and counting
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      error_cnt++;
    end
  endtask

  // Verdict and end of run
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Bounded wait for a level
  task automatic wait_lvl(ref logic sig, input logic val, input int lim);
    for (int i = 0; i < lim && sig !== val; i++) @(negedge clk);
  endtask

  // One frame; a forwarded command is noted with its length
  task automatic send(input logic [63:0] tx, input int n, input logic fwd);
    if (fwd) exp_q.push_back({6'(n), tx[63:56]});
    host_u.frame(tx, n, rx);
  endtask

  // Each strobe is matched with the oldest note
  always @(negedge clk) begin
    if (cmd_strobe === 1'b1) begin
      if (exp_q.size() == 0) check("strobe without note", 32'h1, 32'h0);
      else check("command", {cmd_bit_count, cmd_opcode}, exp_q.pop_front());
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == TIMEOUT_CYC) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    wait_clk(6);
    check("deep_sleep", deep_sleep, 1'b0);
    check("ready", commands_ready, 1'b1);
    check("pump", pump_precharge_mode, 1'b0);
    check("stream", stream_mode_active, 1'b0);
    check("status", status_value, 8'h00);
    // Identity, whole and cut short
    send({8'h9f, 56'h0}, 32, 1'b1);
    check("identity", rx[31:0], {8'h0, MAKER_E, TYPE_E, CAP_E});
    check("short frame", cmd_overlong, 1'b0);
    send({8'h9f, 56'h0}, 16, 1'b1);
    check("identity cut", rx[15:0], {8'h0, MAKER_E});
    check("so_oe idle", so_oe, 1'b0);
    check("ready after cut", commands_ready, 1'b1);
    // Maker and part codes in both orders, repeated
    for (int a = 0; a < 2; a++) begin
      send({8'h90, 23'h0, a[0], 32'h0}, 56, 1'b1);
      if (a) check("pair one", rx[23:0], {DEVICE_E, MAKER_E, DEVICE_E});
      else check("pair zero", rx[23:0], {MAKER_E, DEVICE_E, MAKER_E});
    end
    send({8'hab, 56'h0}, 48, 1'b1);
    check("device code", rx[15:0], {DEVICE_E, DEVICE_E});
    // Pump mode entered, then left by each clearing opcode
    foreach (CLR_OPS[i]) begin
      send({8'ha3, 56'h0}, 32, 1'b1);
      wait_lvl(pump_precharge_mode, 1'b1, 40);
      check("pump on", pump_precharge_mode, 1'b1);
      send({CLR_OPS[i], 56'h0}, 8, 1'b1);
      check("pump off", pump_precharge_mode, 1'b0);
    end
    wait_lvl(deep_sleep, 1'b1, 40);
    check("asleep", deep_sleep, 1'b1);
    send({8'h9f, 56'h0}, 32, 1'b0);
    check("asleep identity", rx[31:0], 32'h0);
    send({8'h06, 56'h0}, 8, 1'b0);
    check("still asleep", deep_sleep, 1'b1);
    send({8'hab, 56'h0}, 40, 1'b0);
    check("wake code", rx[7:0], DEVICE_E);
    wait_lvl(commands_ready, 1'b1, 40);
    check("awake", {deep_sleep, commands_ready}, 2'b01);
    send({8'hb9, 56'h0}, 8, 1'b1);
    wait_lvl(deep_sleep, 1'b1, 40);
    send({8'hab, 56'h0}, 8, 1'b0);
    wait_lvl(commands_ready, 1'b1, 40);
    check("wake only", {deep_sleep, commands_ready}, 2'b01);
    // Wake refused while asleep and busy writing
    send({8'hb9, 56'h0}, 8, 1'b1);
    wait_lvl(deep_sleep, 1'b1, 40);
    @(negedge clk) busy_writing_flag = 1'b1;
    send({8'hab, 56'h0}, 8, 1'b0);
    wait_clk(30);
    check("busy wake", deep_sleep, 1'b1);
    @(negedge clk) busy_writing_flag = 1'b0;
    send({8'hab, 56'h0}, 8, 1'b0);
    wait_lvl(commands_ready, 1'b1, 40);
    check("awake again", commands_ready, 1'b1);
    // Sleep refused unless exactly eight bits
    for (int k = 0; k < 3; k++) begin
      send({8'hb9, 56'h0}, k == 0 ? 7 : 8 * k + 1, k != 0);
      wait_clk(30);
      check("no sleep", {deep_sleep, commands_ready}, 2'b01);
    end
    // Busy write cycle blocks sleep, the 9fh identity and the abh device code answer
    @(negedge clk) busy_writing_flag = 1'b1;
    wait_clk(3);
    check("status busy", status_value, 8'h01);
    send({8'hb9, 56'h0}, 8, 1'b1);
    wait_clk(30);
    check("busy sleep", deep_sleep, 1'b0);
    send({8'h9f, 56'h0}, 32, 1'b1);
    check("busy identity", rx[31:0], 32'h0);
    send({8'hab, 56'h0}, 40, 1'b1);
    check("busy wake code", rx[31:0], 32'h0);
    @(negedge clk) busy_writing_flag = 1'b0;
    wait_clk(3);
    check("status idle", status_value, 8'h00);
    // Stream mode hides standard commands until the exit code
    @(negedge clk) stream_read_mode_bits = {4'ha, 4'($random(seed))};
    stream_load = 1'b1;
    @(negedge clk) stream_load = 1'b0;
    wait_clk(2);
    check("stream on", stream_mode_active, 1'b1);
    send({8'h9f, 56'h0}, 32, 1'b0);
    check("stream identity", rx[31:0], 32'h0);
    send({8'hff, 56'h0}, 8, 1'b0);
    check("stream off", stream_mode_active, 1'b0);
    @(negedge clk) stream_read_mode_bits = {1'b0, 7'($random(seed))};
    stream_load = 1'b1;
    @(negedge clk) stream_load = 1'b0;
    wait_clk(2);
    check("other mode", stream_mode_active, 1'b0);
    send({8'h9f, 56'h0}, 32, 1'b1);
    check("identity back", rx[31:0], {8'h0, MAKER_E, TYPE_E, CAP_E});
    send({8'h06, 56'h0}, 64, 1'b1);
    check("overlong", cmd_overlong, 1'b1);
    wait_clk(5);
    check("notes left", exp_q.size(), 32'h0);
    stop_test();
  end
endmodule // flash_power_id_commands_test

// *** flash_power_id_pkg.sv ***
// Shared constants and types for the power-state and identification command block
package flash_power_id_pkg;

  // Command codes
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE_IDENT = 8'hab;
  localparam logic [7:0] OP_MAKER_PART = 8'h90;
  localparam logic [7:0] OP_THREE_ID = 8'h9f;
  localparam logic [7:0] OP_PUMP_ENTER = 8'ha3;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_STREAM_EXIT = 8'hff;

  // Frame lengths in bits
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] HEADER_BITS = 6'h20;
  localparam logic [5:0] ADDR_LSB_BIT = 6'h1f;
  localparam logic [5:0] OPCODE_LAST_BIT = 6'h07;
  localparam logic [5:0] BIT_COUNT_MAX = 6'h3f;

  // Stream read mode bits that keep the read engine in continuous mode
  localparam logic [3:0] STREAM_MODE_KEY = 4'ha;

  // Delivered contents
  localparam logic [7:0] STATUS_DELIVERY = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Timing, in nanoseconds, and derived cycle counts (longest times round down)
  localparam int CLK_PERIOD_NS = 8;
  localparam int SLEEP_ENTRY_DELAY_NS = 100;
  localparam int WAKE_ONLY_DELAY_NS = 100;
  localparam int WAKE_WITH_CODE_DELAY_NS = 100;
  localparam int PUMP_ENTRY_DELAY_NS = 200;
  localparam logic [4:0] SLEEP_ENTRY_CYC = 5'(SLEEP_ENTRY_DELAY_NS / CLK_PERIOD_NS);
  localparam logic [4:0] WAKE_ONLY_CYC = 5'(WAKE_ONLY_DELAY_NS / CLK_PERIOD_NS);
  localparam logic [4:0] WAKE_CODE_CYC = 5'(WAKE_WITH_CODE_DELAY_NS / CLK_PERIOD_NS);
  localparam logic [4:0] PUMP_ENTRY_CYC = 5'(PUMP_ENTRY_DELAY_NS / CLK_PERIOD_NS);

  // Host-side power-on waits, held for reference by the rest of the chip
  localparam int POWER_TO_SELECT_WAIT_US = 10;
  localparam int POWER_TO_WRITE_WAIT_MIN_MS = 1;
  localparam int POWER_TO_WRITE_WAIT_MAX_MS = 10;

  // Power states
  typedef enum logic [1:0] {
    ps_standby = 2'b00,
    ps_entering = 2'b01,
    ps_asleep = 2'b10,
    ps_waking = 2'b11
  } power_state_t;

endpackage

// *** spi_host_model.sv ***
// Serial host model that frames commands and collects the answer bits
`timescale 1ns/1ps
module spi_host_model (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  // Idle link: clock low and still; select rises once all logic waits, arming the frame
  initial begin
    sclk = 1'b0;
    si = 1'b0;
    #1 cs_n = 1'b1;
  end

  // One frame: tx leaves from bit 63 down, so is taken at every rising edge
  task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = 64'h0;
    #3 cs_n = 1'b0;
    #20;
    for (int i = 0; i < n; i++) begin
      si = tx[63 - i];
      #32 sclk = 1'b1;
      rx = {rx[62:0], so};
      #32 sclk = 1'b0;
    end
    #20 cs_n = 1'b1;
    si = ~si;
    // Select stays high and the clock still until the frame end is taken
    #200;
  endtask
endmodule // spi_host_model
